/* hdl/adc_port_map.svh */
// constants of the converter output port
//
// Notes on behaviour
// R1: every result is a 10-bit parallel word
// R2: result appears five clocks after its sample; the code takes six, five delay stages plus the output flop
// R3: coding is straight offset binary, full scale ones
// R4: midscale top bit only, ends zeros and ones
// R5: output disable high floats all data outputs
// R6: disable low or floating drives outputs normally
// R7: partner keeps output disable static while sampling
// R8: power-down high enters low-current power-down mode
// R9: floating power-down pin means normal operation
// R10: outputs stay high impedance throughout power-down
// R11: samples taken while powered down are invalid
// R12: five invalid words follow power-down release
// R13: partner clocks at most 20 Msps, near 50%; the bench clocks at 40 Msps
// R14: one sample in, one result out per edge
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// ============================================================
// word layout
`define DATA_W        10
`define DATA_MSB      9
`define CODE_MIDSCALE 10'h200
`define CODE_ZERO     10'h000
`define CODE_ONES     10'h3FF

// ============================================================
// pipeline and recovery timing, in sample clocks
`define LATENCY       5
`define STAGES        5
`define WAKE_CYCLES   3'h5
`define WAKE_W        3
`define WAKE_ONE      3'h1
`define WAKE_NONE     3'h0

// ============================================================
// pin resting levels, held by the internal pull-downs
`define PIN_REST      1'b0

`endif

/* hdl/adc_port_pkg.sv */
// types of the converter output port
package adc_port_pkg;

  // ============================================================
  // operating mode
  typedef enum logic [1:0] {
    MODE_RUN  = 2'b00,
    MODE_DOWN = 2'b01,
    MODE_WAKE = 2'b10
  } mode_type;

endpackage

/* hdl/pin_sync.sv */
// three-flop synchroniser with agreement filter for a static pin
`timescale 1ns/1ps
`include "adc_port_map.svh"

module pin_sync (
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  input  wire logic pin_in,
  output logic      level_out
);

  logic meta_r;
  logic mid_r;
  logic last_r;
  logic level_r;
  logic level_nxt;

  // ============================================================
  // filter: a change counts once the second and third flops agree
  always_comb begin
    level_nxt = level_r;
    if (mid_r == last_r) begin
      level_nxt = last_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      meta_r  <= `PIN_REST;
      mid_r   <= `PIN_REST;
      last_r  <= `PIN_REST;
      level_r <= `PIN_REST;
    end else begin
      meta_r  <= pin_in;
      mid_r   <= meta_r;
      last_r  <= mid_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule

/* hdl/result_delay.sv */
// fixed-length delay line aligning results with their samples
`timescale 1ns/1ps
`include "adc_port_map.svh"

module result_delay (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [`DATA_MSB:0]    code_in,
  input  wire logic                  valid_in,
  output logic      [`DATA_MSB:0]    code_out,
  output logic                       valid_out
);

  logic [`DATA_MSB:0] code_r  [`STAGES];
  logic               valid_r [`STAGES];
  logic [`DATA_MSB:0] code_nxt  [`STAGES];
  logic               valid_nxt [`STAGES];

  // ============================================================
  // one step per edge, every stage
  genvar g;
  generate
    for (g = 0; g < `STAGES; g++) begin : g_stage
      // the head stage is split off so no stage ever indexes below zero
      if (g == 0) begin : g_head
        always_comb begin
          code_nxt[g]  = code_in;
          valid_nxt[g] = valid_in;
        end
      end else begin : g_body
        always_comb begin
          code_nxt[g]  = code_r[g-1];
          valid_nxt[g] = valid_r[g-1];
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
          code_r[g]  <= `CODE_ZERO;
          valid_r[g] <= 1'b0;
        end else begin
          code_r[g]  <= code_nxt[g];   // R14
          valid_r[g] <= valid_nxt[g];
        end
      end
    end
  endgenerate

  assign code_out  = code_r[`STAGES-1];
  assign valid_out = valid_r[`STAGES-1];

endmodule

/* hdl/adc_output_port.sv */
// digital output side of a pipelined 10-bit sampling converter
`timescale 1ns/1ps
`include "adc_port_map.svh"

module adc_output_port (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rstn_in,
  input  wire logic signed [`DATA_MSB:0] sample_in,
  input  wire logic                    out_disable_in,
  input  wire logic                    power_down_in,
  output logic        [`DATA_MSB:0]    data_out,
  output logic        [`DATA_MSB:0]    data_oe_out,
  output logic                         data_valid_out,
  output logic                         low_power_out,
  output adc_port_pkg::mode_type       mode_out
);

  import adc_port_pkg::*;

  logic               disable_lvl;
  logic               down_lvl;
  logic [`DATA_MSB:0] code_conv;
  logic [`DATA_MSB:0] code_late;
  logic               valid_late;

  mode_type           mode_r;
  mode_type           mode_nxt;
  logic [`WAKE_W-1:0] wake_r;
  logic [`WAKE_W-1:0] wake_nxt;

  logic [`DATA_MSB:0] data_r;
  logic [`DATA_MSB:0] data_nxt;
  logic               valid_r;
  logic               valid_nxt;
  logic               drive_r;
  logic               drive_nxt;

  // ============================================================
  // static pins; the pull-downs make a floating pin read low
  pin_sync u_disable_sync (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .pin_in     (out_disable_in),
    .level_out  (disable_lvl)
  );

  pin_sync u_down_sync (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .pin_in     (power_down_in),
    .level_out  (down_lvl)
  );

  // ============================================================
  // coding: flipping the sign bit gives straight offset binary
  assign code_conv = {~sample_in[`DATA_MSB], sample_in[`DATA_MSB-1:0]};  // R1 R3 R4

  // a sample is only good if the core was awake when it was taken
  result_delay u_delay (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .code_in    (code_conv),
    .valid_in   (~down_lvl),         // R11
    .code_out   (code_late),
    .valid_out  (valid_late)
  );

  // ============================================================
  // mode control
  always_comb begin
    mode_nxt = mode_r;
    wake_nxt = wake_r;
    unique case (mode_r)
      MODE_RUN: begin
        if (down_lvl) begin
          mode_nxt = MODE_DOWN;      // R8
        end
      end
      MODE_DOWN: begin
        if (!down_lvl) begin
          mode_nxt = MODE_WAKE;
          wake_nxt = `WAKE_CYCLES;   // R12
        end
      end
      MODE_WAKE: begin
        if (down_lvl) begin
          mode_nxt = MODE_DOWN;
          wake_nxt = `WAKE_NONE;
        end else if (wake_r == `WAKE_ONE) begin
          mode_nxt = MODE_RUN;
          wake_nxt = `WAKE_NONE;
        end else begin
          wake_nxt = wake_r - `WAKE_ONE;  // R12
        end
      end
      default: begin
        mode_nxt = MODE_RUN;
        wake_nxt = `WAKE_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      mode_r <= MODE_RUN;            // R9
      wake_r <= `WAKE_NONE;
    end else begin
      mode_r <= mode_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ============================================================
  // output stage; the partner must keep the disable pin static,
  // toggling it only glitches the bus, it never corrupts the pipe
  always_comb begin
    data_nxt  = code_late;           // R2 R14
    valid_nxt = valid_late && (mode_nxt == MODE_RUN);  // R11 R12
    drive_nxt = !disable_lvl && (mode_nxt != MODE_DOWN);  // R5 R6 R7 R10
    if (mode_nxt == MODE_DOWN) begin
      data_nxt = `CODE_ZERO;         // R10
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      data_r  <= `CODE_ZERO;
      valid_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      data_r  <= data_nxt;
      valid_r <= valid_nxt;
      drive_r <= drive_nxt;
    end
  end

  // one enable per data bit, all driven from the same flop
  genvar b;
  generate
    for (b = 0; b < `DATA_W; b++) begin : g_oe
      assign data_oe_out[b] = drive_r;   // R5 R10
    end
  endgenerate

  assign data_out       = data_r;
  assign data_valid_out = valid_r;
  assign low_power_out  = (mode_r == MODE_DOWN);  // R8
  assign mode_out       = mode_r;

endmodule

/* test/adc_port_assertions.sv */
// concurrent checks on the converter output port
`timescale 1ns/1ps
`include "adc_port_map.svh"
module adc_port_checker (
  input wire logic                        sys_clk_in,
  input wire logic                        rstn_in,
  input wire logic signed [`DATA_MSB:0]   sample_in,
  input wire logic                        out_disable_in,
  input wire logic                        power_down_in,
  input wire logic        [`DATA_MSB:0]   data_out,
  input wire logic        [`DATA_MSB:0]   data_oe_out,
  input wire logic                        data_valid_out,
  input wire logic                        low_power_out,
  input wire adc_port_pkg::mode_type      mode_out
);
  import adc_port_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // ============================================================
  // output word and modes
  a_word_latency: assert property (data_valid_out |->
    data_out == {~$past(sample_in[9], 6), $past(sample_in[8:0], 6)}) else $error("bad word");
  a_down_quiet: assert property (low_power_out |->
    data_oe_out == '0 && !data_valid_out && data_out == '0) else $error("live in down");
  a_lp_mode: assert property (power_down_in [*6] |->
    low_power_out && mode_out == MODE_DOWN) else $error("low power flag");
  a_pd_entry: assert property ($rose(power_down_in) |-> ##[4:6] low_power_out)
    else $error("no power-down");
  a_pd_invalid: assert property (power_down_in [*6] |-> ##6 !data_valid_out)
    else $error("valid from down sample");
  a_wake_span: assert property ($fell(low_power_out) |->
    (mode_out == MODE_WAKE && !data_valid_out) [*5] ##1 mode_out == MODE_RUN)
    else $error("wake span");
  a_disable_float: assert property (out_disable_in [*6] |-> data_oe_out == '0)
    else $error("not floated");
  a_enable_drive: assert property ((!out_disable_in && !low_power_out) [*6] |->
    data_oe_out == '1) else $error("not driven");
endmodule

bind adc_output_port adc_port_checker chk (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sample_in(sample_in),
  .out_disable_in(out_disable_in), .power_down_in(power_down_in), .data_out(data_out),
  .data_oe_out(data_oe_out), .data_valid_out(data_valid_out),
  .low_power_out(low_power_out), .mode_out(mode_out)
);

/* test/capture_model.sv */
// capture logic model latching valid words off the output pins
`timescale 1ns/1ps
`include "adc_port_map.svh"
module capture_model (
  input  wire logic                 sys_clk_in,
  input  wire logic [`DATA_MSB:0]   bus_in,
  input  wire logic                 valid_in,
  output logic      [`DATA_MSB:0]   word_out,
  output int                        count_out
);
  int count_r = 0;
  assign count_out = count_r;
  // only words flagged valid are latched; words during wake are dropped
  always @(posedge sys_clk_in) begin
    if (valid_in) begin
      word_out <= bus_in;
      count_r  <= count_r + 1;
    end
  end
endmodule

/* test/adc_output_port_tb_top.sv */
// self-checking bench for the converter output port
`timescale 1ns/1ps
`include "adc_port_map.svh"
module adc_output_port_tb_top;
  import adc_port_pkg::*;
  logic                      sys_clk_in;
  logic                      rstn_in;
  logic signed [`DATA_MSB:0] sample_in;
  logic                      out_disable_in;
  logic                      power_down_in;
  logic        [`DATA_MSB:0] data_out;
  logic        [`DATA_MSB:0] data_oe_out;
  logic                      data_valid_out;
  logic                      low_power_out;
  mode_type                  mode_out;
  wire         [`DATA_MSB:0] bus_w;
  logic        [`DATA_MSB:0] word_w;
  int                        words;
  int                        miscompares = 0;
  int                        num_checks = 0;
  int                        cycles = 0;
  // ============================================================
  // pins, design and far side
  for (genvar b = 0; b < `DATA_W; b++) begin : g_pin
    assign bus_w[b] = data_oe_out[b] ? data_out[b] : 1'bz;
  end
  adc_output_port dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sample_in(sample_in),
    .out_disable_in(out_disable_in), .power_down_in(power_down_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_valid_out(data_valid_out),
    .low_power_out(low_power_out), .mode_out(mode_out));
  capture_model cap (.sys_clk_in(sys_clk_in), .bus_in(bus_w), .valid_in(data_valid_out),
    .word_out(word_w), .count_out(words));
  // ============================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic check(input logic [`DATA_MSB:0] seen, input logic [`DATA_MSB:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ============================================================
  // scenarios
  task automatic run_codes();
    logic [`DATA_MSB:0] s [8] = '{10'h200, 10'h201, 10'h3FF, 10'h000,
                                  10'h001, 10'h100, 10'h1FE, 10'h1FF};
    logic [`DATA_MSB:0] e [8] = '{10'h000, 10'h001, 10'h1FF, 10'h200,
                                  10'h201, 10'h300, 10'h3FE, 10'h3FF};
    for (int j = 0; j < 14; j++) begin
      if (j >= 6) begin
        check(data_valid_out, 1'b1, "valid");
        check(bus_w, e[j-6], "word");
      end
      sample_in = (j < 8) ? s[j] : 10'h000;
      tick(1);
    end
    check(word_w, 10'h3FF, "captured");
  endtask
  task automatic run_disable();
    out_disable_in = 1'b1;
    tick(8);
    check(bus_w, {`DATA_W{1'bz}}, "floated");
    check(data_valid_out, 1'b1, "valid floated");
    out_disable_in = 1'b0;
    tick(8);
    check(data_oe_out, 10'h3FF, "driven");
  endtask
  task automatic run_power();
    int n;
    int w;
    sample_in = 10'h1FF;
    power_down_in = 1'b1;
    tick(8);
    check(low_power_out, 1'b1, "low power");
    check(mode_out, MODE_DOWN, "mode down");
    check(bus_w, {`DATA_W{1'bz}}, "floated down");
    w = words;
    tick(20);
    check(10'(words - w), 10'h000, "words in down");
    power_down_in = 1'b0;
    n = 0;
    while (low_power_out === 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check(mode_out, MODE_WAKE, "mode wake");
    check(data_valid_out, 1'b0, "valid wake");
    check(data_oe_out, 10'h3FF, "driven wake");
    n = 0;
    while (data_valid_out !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check(10'(n), 10'(`WAKE_CYCLES), "invalid span");
    check(bus_w, 10'h3FF, "first word");
  endtask
  // ============================================================
  // clock, timeout and main sequence
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // the run needs well under 200 cycles; a hang is cut at 3000
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rstn_in = 1'b0;
    sample_in = 10'h000;
    out_disable_in = 1'b0;
    power_down_in = 1'b0;
    tick(16);
    check(data_oe_out, 10'h000, "oe in reset");
    check(mode_out, MODE_RUN, "mode in reset");
    rstn_in = 1'b1;
    tick(8);
    run_codes();
    run_disable();
    run_power();
    final_report();
  end
endmodule
